// File: hw/nav_packet_codec.sv
// packet decoder and encoder for the navigation unit binary protocol
`timescale 1ns/1ps
`default_nettype none
`include "nav_packet_codec_defs.svh"
module nav_packet_codec
(
   input  wire logic          clock,
   input  wire logic          srst,
   // received packet stream, one byte a cycle while rxValid
   input  wire logic          rxValid,
   input  wire logic          rxFirst,
   input  wire logic          rxLast,
   input  wire logic [7:0]    rxId,
   input  wire logic [7:0]    rxLen,
   input  wire logic [7:0]    rxData,
   output logic               zavStrobe,
   output logic      [31:0]   zavDuration,
   output logic               cfgStrobe,
   output logic      [7:0]    cfgId,
   output logic               cfgPermanent,
   output logic               rxDropped,
   // satellite record load, epoch and temperature requests
   input  wire logic          satWrEn,
   input  wire logic [5:0]    satWrAddr,
   input  wire logic [71:0]   satWrData,
   output logic               satWrRejected,
   input  wire logic          epochStart,
   input  wire logic [5:0]    satCount,
   input  wire logic          tempStart,
   input  wire logic [255:0]  tempData,
   output logic               encBusy,
   // transmitted packet stream
   output logic               txValid,
   input  wire logic          txReady,
   output logic               txFirst,
   output logic               txLast,
   output logic      [7:0]    txId,
   output logic      [7:0]    txLen,
   output logic      [7:0]    txData
);
   // ********************
   // decoder
   // ********************
   logic [7:0]  rxCnt_q;
   logic        rxBad_q;
   logic [63:0] rxBuf_q;
   logic [7:0]  curId_q;
   logic [7:0]  curLen_q;
   logic        hdrOk;
   logic [7:0]  cnt;

   // host-writable ids and their lengths, fixed except for id B5
   function automatic logic lenOk(input logic [7:0] id, input logic [7:0] len);
      case (id)
         `ID_ZAV:  lenOk = (len == `LEN_ZAV);
         8'hB4:    lenOk = (len == 8'h04);
         `ID_PERIODS: lenOk = (len >= `PERIODS_HDR) &&
                              (((len - `PERIODS_HDR) % `PERIODS_STEP) == 8'h00);
         8'hB6:    lenOk = (len == 8'h11);
         8'hB8:    lenOk = (len == 8'h04);
         8'hB9:    lenOk = (len == 8'h49);
         8'hBA:    lenOk = (len == 8'h11);
         8'hBC:    lenOk = (len == 8'h0D);
         8'hBD:    lenOk = (len == 8'h31);
         `ID_MAGCFG: lenOk = (len == 8'h01);
         8'hC0:    lenOk = (len == 8'h08);
         `ID_ZEROALIGN: lenOk = (len == 8'h05);
         8'hC2:    lenOk = (len == 8'h31);
         8'hC3:    lenOk = (len == 8'hB7);
         8'hC4:    lenOk = (len == 8'h11);
         8'hC5:    lenOk = (len == 8'h55);
         8'hC6:    lenOk = (len == 8'h40);
         8'hC7:    lenOk = (len == 8'h41);
         8'hCA:    lenOk = (len == 8'h1E);
         8'hCB:    lenOk = (len == 8'h1E);
         default:  lenOk = 1'b0; // read-only ids such as 84, 85, 191 fall here
      endcase
   endfunction

   assign hdrOk = lenOk(rxId, rxLen);
   assign cnt = rxFirst ? 8'h00 : rxCnt_q;

   // byte counting and capture; a bad header poisons the whole packet
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rxCnt_q <= 8'h00;
         rxBad_q <= 1'b0;
         rxBuf_q <= 64'h0;
         curId_q <= 8'h00;
         curLen_q <= 8'h00;
      end
      else if (rxValid)
      begin
         rxCnt_q <= cnt + 8'h01;
         if (rxFirst)
         begin
            rxBad_q <= !hdrOk;
            curId_q <= rxId;
            curLen_q <= rxLen;
         end
         if (cnt < 8'h08)
            rxBuf_q[{cnt[2:0], 3'b000} +: 8] <= rxData;
      end
   end

   logic [63:0] fullBuf;
   logic [7:0]  id;
   logic        good;
   assign fullBuf = (cnt < 8'h08) ? (rxBuf_q & ~(64'hFF << {cnt[2:0], 3'b000})) |
                    ({56'h0, rxData} << {cnt[2:0], 3'b000}) : rxBuf_q;
   assign id = rxFirst ? rxId : curId_q;
   // byte total must match the announced length; reserved word of id 83 must be zero
   assign good = (rxFirst ? hdrOk : !rxBad_q) &&
                 ((cnt + 8'h01) == (rxFirst ? rxLen : curLen_q)) &&
                 (id != `ID_ZAV || fullBuf[63:32] == 32'h0);

   // commit settings only at the last byte of an accepted packet
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         zavStrobe <= 1'b0;
         zavDuration <= 32'h0;
         cfgStrobe <= 1'b0;
         cfgId <= 8'h00;
         cfgPermanent <= 1'b0;
         rxDropped <= 1'b0;
      end
      else
      begin
         zavStrobe <= 1'b0;
         cfgStrobe <= 1'b0;
         rxDropped <= rxValid && rxLast && !good;
         if (rxValid && rxLast && good)
         begin
            if (id == `ID_ZAV)
            begin
               zavStrobe <= 1'b1;
               zavDuration <= fullBuf[31:0];
            end
            else
            begin
               cfgStrobe <= 1'b1;
               cfgId <= id;
               // the single-byte and alignment commands carry no persistence byte
               cfgPermanent <= (id != `ID_MAGCFG) && (id != `ID_ZEROALIGN) &&
                               (fullBuf[7:0] == 8'h01);
            end
         end
      end
   end

   // ********************
   // satellite record store
   // ********************
   logic        recOk;
   logic [5:0]  rdAddr;
   logic [71:0] rdData;
   // system code and frequency code range check before storing
   assign recOk = (satWrData[7:0] <= `SYS_MAX) &&
                  (satWrData[23:16] <= `FREQ_MAX);

   always_ff @(posedge clock)
   begin
      if (srst)
         satWrRejected <= 1'b0;
      else
         satWrRejected <= satWrEn && !recOk;
   end

   sat_record_mem #(.AW(`SAT_AW), .DW(72)) recMem
   (
      .clock  (clock),
      .wrEn   (satWrEn && recOk),
      .wrAddr (satWrAddr),
      .wrData (satWrData),
      .rdAddr (rdAddr),
      .rdData (rdData)
   );

   // ********************
   // encoder
   // ********************
   nav_packet_codec_pkg::enc_state_t state_q;
   logic [7:0]  pos_q;
   logic [7:0]  pktLen_q;
   logic [7:0]  pktTotal_q;
   logic [7:0]  pktNum_q;
   logic [5:0]  recIdx_q;
   logic [7:0]  recLeft_q;
   logic [7:0]  recInPkt_q;
   logic [3:0]  recByte_q;
   logic [255:0] temp_q;
   logic        load;
   logic        lastByte;
   logic [7:0]  nextRecs;
   logic [7:0]  byteOut;

   assign load = (state_q != nav_packet_codec_pkg::EncIdle) && (!txValid || txReady);
   assign lastByte = (pos_q + 8'h01) == pktLen_q;
   assign encBusy = state_q != nav_packet_codec_pkg::EncIdle;
   // size of the following packet, judged at the last byte of this one: the final record
   // of this packet is not yet off the count, so one more is taken away here
   assign nextRecs = ((recLeft_q - 8'h01) > `REC_MAX) ? `REC_MAX : recLeft_q - 8'h01;
   // read address runs one step ahead since the store answers a cycle late
   assign rdAddr = (load && state_q == nav_packet_codec_pkg::EncSat && pos_q >= `EXTSAT_HDR &&
                    recByte_q == 4'h8) ? recIdx_q + 6'h01 : recIdx_q;

   // byte selection for the packet under way
   always_comb
   begin
      byteOut = 8'h00;
      if (state_q == nav_packet_codec_pkg::EncTemp)
         byteOut = temp_q[{pos_q[4:0], 3'b000} +: 8];
      else if (pos_q == 8'h00)
         byteOut = pktTotal_q;
      else if (pos_q == 8'h01)
         byteOut = pktNum_q;
      else if (recByte_q == 4'h8)
         byteOut = rdData[71:64] & `FLAG_MASK;
      else
         byteOut = rdData[{recByte_q[2:0], 3'b000} +: 8];
   end

   // packet sequencing; an idle epoch still reports one empty packet
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_q <= nav_packet_codec_pkg::EncIdle;
         pos_q <= 8'h00;
         pktLen_q <= 8'h00;
         pktTotal_q <= 8'h00;
         pktNum_q <= 8'h00;
         recIdx_q <= 6'h00;
         recLeft_q <= 8'h00;
         recInPkt_q <= 8'h00;
         recByte_q <= 4'h0;
         temp_q <= 256'h0;
      end
      else
      begin
         case (state_q)
            nav_packet_codec_pkg::EncIdle:
            begin
               pos_q <= 8'h00;
               recByte_q <= 4'h0;
               if (epochStart)
               begin
                  state_q <= nav_packet_codec_pkg::EncSat;
                  recIdx_q <= 6'h00;
                  recLeft_q <= {2'b00, satCount};
                  pktNum_q <= 8'h01;
                  pktTotal_q <= (satCount == 6'h00) ? 8'h01 :
                                8'((8'(satCount) + `REC_MAX - 8'h01) / `REC_MAX);
                  recInPkt_q <= (8'(satCount) > `REC_MAX) ? `REC_MAX : 8'(satCount);
                  pktLen_q <= 8'(`EXTSAT_HDR + `REC_BYTES *
                              ((8'(satCount) > `REC_MAX) ? `REC_MAX : 8'(satCount)));
               end
               else if (tempStart)
               begin
                  state_q <= nav_packet_codec_pkg::EncTemp;
                  temp_q <= tempData;
                  pktLen_q <= `LEN_TEMP;
               end
            end
            nav_packet_codec_pkg::EncSat:
            begin
               if (load)
               begin
                  pos_q <= lastByte ? 8'h00 : pos_q + 8'h01;
                  if (pos_q >= `EXTSAT_HDR)
                  begin
                     recByte_q <= (recByte_q == 4'h8) ? 4'h0 : recByte_q + 4'h1;
                     if (recByte_q == 4'h8)
                     begin
                        recIdx_q <= recIdx_q + 6'h01;
                        recLeft_q <= recLeft_q - 8'h01;
                     end
                  end
                  if (lastByte)
                  begin
                     if (pktNum_q == pktTotal_q)
                        state_q <= nav_packet_codec_pkg::EncIdle;
                     else
                     begin
                        pktNum_q <= pktNum_q + 8'h01;
                        recInPkt_q <= nextRecs;
                        pktLen_q <= 8'(`EXTSAT_HDR + `REC_BYTES * nextRecs);
                     end
                  end
               end
            end
            nav_packet_codec_pkg::EncTemp:
            begin
               if (load)
               begin
                  pos_q <= pos_q + 8'h01;
                  if (lastByte)
                     state_q <= nav_packet_codec_pkg::EncIdle;
               end
            end
            default:
               state_q <= nav_packet_codec_pkg::EncIdle;
         endcase
      end
   end

   // output stage: held while the receiver stalls
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         txValid <= 1'b0;
         txFirst <= 1'b0;
         txLast <= 1'b0;
         txId <= 8'h00;
         txLen <= 8'h00;
         txData <= 8'h00;
      end
      else if (load)
      begin
         txValid <= 1'b1;
         txFirst <= pos_q == 8'h00;
         txLast <= lastByte;
         txId <= (state_q == nav_packet_codec_pkg::EncTemp) ? `ID_TEMP : `ID_EXTSAT;
         txLen <= pktLen_q;
         txData <= byteOut;
      end
      else if (txReady)
         txValid <= 1'b0;
   end

   // ********************
   // checks
   // ********************
   sequence zavLastGood_s;
      rxValid && rxLast && good && id == `ID_ZAV;
   endsequence
   zav_commit_a: assert property (@(posedge clock) disable iff (srst)
      zavLastGood_s |=> zavStrobe && zavDuration == $past(fullBuf[31:0]))
      else $error("zero velocity duration not committed");
   drop_readonly_a: assert property (@(posedge clock) disable iff (srst)
      rxValid && rxFirst && (rxId == `ID_EXTSAT || rxId == `ID_MAGSTAT) |-> !hdrOk)
      else $error("read-only id accepted");
   drop_no_change_a: assert property (@(posedge clock) disable iff (srst)
      rxDropped |-> !zavStrobe && !cfgStrobe && $stable(zavDuration))
      else $error("dropped packet changed a setting");
   sat_len_a: assert property (@(posedge clock) disable iff (srst)
      txValid && txId == `ID_EXTSAT |-> txLen >= `EXTSAT_HDR &&
      (txLen - `EXTSAT_HDR) % `REC_BYTES == 8'h00)
      else $error("satellite packet length malformed");
   sat_max_a: assert property (@(posedge clock) disable iff (srst)
      txValid && txId == `ID_EXTSAT |-> txLen <= 8'hFE)
      else $error("more than 28 records in a packet");
   rec_count_a: assert property (@(posedge clock) disable iff (srst)
      state_q == nav_packet_codec_pkg::EncSat |-> recInPkt_q <= `REC_MAX &&
      pktLen_q == 8'(`EXTSAT_HDR + `REC_BYTES * recInPkt_q))
      else $error("packet length and record count disagree");
   epoch_end_a: assert property (@(posedge clock) disable iff (srst)
      state_q == nav_packet_codec_pkg::EncSat && load && lastByte && pktNum_q == pktTotal_q
      |-> recLeft_q <= 8'h01)
      else $error("epoch ended with records left over");
   seq_range_a: assert property (@(posedge clock) disable iff (srst)
      state_q == nav_packet_codec_pkg::EncSat |-> pktNum_q >= 8'h01 && pktNum_q <= pktTotal_q)
      else $error("sequence number out of range");
   seq_step_a: assert property (@(posedge clock) disable iff (srst)
      state_q == nav_packet_codec_pkg::EncSat && load && lastByte && pktNum_q != pktTotal_q
      |=> pktNum_q == $past(pktNum_q) + 8'h01 && pktTotal_q > 8'h01)
      else $error("split epoch numbering broken");
   flags_zero_a: assert property (@(posedge clock) disable iff (srst)
      load && state_q == nav_packet_codec_pkg::EncSat && pos_q >= `EXTSAT_HDR &&
      recByte_q == 4'h8 |=> txData[7:4] == 4'h0)
      else $error("reserved flag bits set");
   temp_len_a: assert property (@(posedge clock) disable iff (srst)
      tempStart && state_q == nav_packet_codec_pkg::EncIdle && !epochStart && !txValid
      |=> pktLen_q == `LEN_TEMP ##1 txValid && txFirst && txId == `ID_TEMP)
      else $error("temperature packet header wrong");
   rec_range_a: assert property (@(posedge clock) disable iff (srst)
      satWrEn && (satWrData[7:0] > `SYS_MAX || satWrData[23:16] > `FREQ_MAX)
      |=> satWrRejected)
      else $error("invalid record stored");
endmodule
`default_nettype wire

// File: hw/nav_packet_codec_defs.svh
// constants for the navigation packet codec
`ifndef NAV_PACKET_CODEC_DEFS_SVH
`define NAV_PACKET_CODEC_DEFS_SVH
`define ID_ZAV        8'h53
`define LEN_ZAV       8'h08
`define ID_EXTSAT     8'h54
`define EXTSAT_HDR    8'h02
`define REC_BYTES     8'h09
`define REC_MAX       8'h1C
`define ID_TEMP       8'h55
`define LEN_TEMP      8'h20
`define SYS_MAX       8'h09
`define FREQ_MAX      8'h0A
`define FLAG_MASK     8'h0F
`define ID_PERIODS    8'hB5
`define PERIODS_HDR   8'h02
`define PERIODS_STEP  8'h05
`define ID_MAGCFG     8'hBE
`define ID_MAGSTAT    8'hBF
`define ID_ZEROALIGN  8'hC1
`define SAT_AW        6
`endif

// File: hw/nav_packet_codec_pkg.sv
// types shared by the navigation packet codec
package nav_packet_codec_pkg;
   typedef enum logic [3:0] {SysUnknown, SysGps, SysGlonass, SysBeidou, SysGalileo,
                             SysSbas, SysQzss, SysRes7, SysRes8, SysRes9} sat_system_t;
   typedef enum {EncIdle, EncSat, EncTemp} enc_state_t;
endpackage

// File: hw/sat_record_mem.sv
// satellite record store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sat_record_mem
#(
   parameter int AW = 6,
   parameter int DW = 72
)
(
   input  wire logic          clock,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output logic      [DW-1:0] rdData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // write port and registered read port
   always_ff @(posedge clock)
   begin
      if (wrEn)
         mem[wrAddr] <= wrData;
      rdData <= mem[rdAddr];
   end
endmodule
`default_nettype wire

// File: tb/nav_host_model.sv
// host-side model: feeds packets to the codec and accepts its output stream
`timescale 1ns/1ps
`default_nettype none
module nav_host_model
(
   input  wire logic       clock,
   output logic            rxValid,
   output logic            rxFirst,
   output logic            rxLast,
   output logic      [7:0] rxId,
   output logic      [7:0] rxLen,
   output logic      [7:0] rxData,
   input  wire logic       txValid,
   output logic            txReady,
   input  wire logic       txFirst,
   input  wire logic       txLast,
   input  wire logic [7:0] txId,
   input  wire logic [7:0] txLen,
   input  wire logic [7:0] txData
);
   // ****************************************
   // packet queues and stall control
   // ****************************************
   logic [7:0]  pay[$];
   logic [25:0] got[$];
   int          stallPct = 0;

   // idle lines at time zero
   initial
   begin
      rxValid = 1'b0;
      rxFirst = 1'b0;
      rxLast = 1'b0;
      rxId = 8'h00;
      rxLen = 8'h00;
      rxData = 8'h00;
      txReady = 1'b1;
   end

   // one byte a cycle; between packets the lines flip so stale bytes cannot pass
   task automatic send(input logic [7:0] id, input logic [7:0] len);
      int n;
      n = pay.size();
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock);
         #1;
         rxValid = 1'b1;
         rxFirst = (i == 0);
         rxLast = (i == n - 1);
         rxId = (i == 0) ? id : ~rxId;
         rxLen = (i == 0) ? len : ~rxLen;
         rxData = pay[i];
      end
      @(posedge clock);
      #1;
      rxValid = 1'b0;
      rxFirst = 1'b0;
      rxLast = 1'b0;
      rxId = ~rxId;
      rxLen = ~rxLen;
      rxData = ~rxData;
      pay.delete();
   endtask

   // random back-pressure, changed just after each edge
   always @(posedge clock)
   begin
      #1;
      txReady <= (int'($urandom_range(99)) >= stallPct);
   end

   // accepted bytes; id and length are only meaningful on the first byte
   always @(posedge clock)
   begin
      if (txValid === 1'b1 && txReady === 1'b1)
         got.push_back({txFirst, txLast, txFirst ? txId : 8'h00, txFirst ? txLen : 8'h00, txData});
   end
endmodule
`default_nettype wire

// File: tb/test_nav_packet_codec.sv
// self-checking bench for the navigation packet codec
`timescale 1ns/1ps
`default_nettype none
`include "nav_packet_codec_defs.svh"
module test_nav_packet_codec;
   logic         clock = 1'b0;
   logic         srst = 1'b1;
   logic         satWrEn = 1'b0;
   logic         epochStart = 1'b0;
   logic         tempStart = 1'b0;
   logic         rxValid, rxFirst, rxLast, zavStrobe, cfgStrobe, cfgPermanent, rxDropped;
   logic         satWrRejected, encBusy, txValid, txReady, txFirst, txLast;
   logic [7:0]   rxId, rxLen, rxData, cfgId, txId, txLen, txData;
   logic [31:0]  zavDuration;
   logic [5:0]   satWrAddr = 6'h00;
   logic [5:0]   satCount = 6'h00;
   logic [71:0]  satWrData = 72'h0;
   logic [255:0] tempData = 256'h0;
   logic [71:0]  rec[64];
   logic [25:0]  exq[$];
   int           mismatches = 0;
   int           nCompared = 0;

   // 40 MHz clock
   always #12.5 clock = ~clock;

   nav_packet_codec i_dut
   (
      .clock(clock), .srst(srst), .rxValid(rxValid), .rxFirst(rxFirst), .rxLast(rxLast),
      .rxId(rxId), .rxLen(rxLen), .rxData(rxData), .zavStrobe(zavStrobe),
      .zavDuration(zavDuration), .cfgStrobe(cfgStrobe), .cfgId(cfgId),
      .cfgPermanent(cfgPermanent), .rxDropped(rxDropped), .satWrEn(satWrEn),
      .satWrAddr(satWrAddr), .satWrData(satWrData), .satWrRejected(satWrRejected),
      .epochStart(epochStart), .satCount(satCount), .tempStart(tempStart),
      .tempData(tempData), .encBusy(encBusy), .txValid(txValid), .txReady(txReady),
      .txFirst(txFirst), .txLast(txLast), .txId(txId), .txLen(txLen), .txData(txData)
   );

   nav_host_model i_host
   (
      .clock(clock), .rxValid(rxValid), .rxFirst(rxFirst), .rxLast(rxLast), .rxId(rxId),
      .rxLen(rxLen), .rxData(rxData), .txValid(txValid), .txReady(txReady),
      .txFirst(txFirst), .txLast(txLast), .txId(txId), .txLen(txLen), .txData(txData)
   );

   // ****************************************
   // checking and stimulus helpers
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      nCompared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic finalReport();
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic logic [25:0] ent(input logic f, input logic l, input logic [7:0] id,
                                        input logic [7:0] len, input logic [7:0] d);
      return {f, l, f ? id : 8'h00, f ? len : 8'h00, d};
   endfunction

   // first byte chosen, the rest random
   task automatic fill(input int n, input logic [7:0] b0);
      i_host.pay.push_back(b0);
      for (int i = 1; i < n; i++)
         i_host.pay.push_back(8'($urandom));
   endtask

   // code: 4 duration accepted, 2 config accepted, 1 dropped
   task automatic rxPkt(input logic [7:0] id, input logic [7:0] len, input logic [2:0] code);
      i_host.send(id, len);
      chk("rxOutcome", 32'(code), 32'({zavStrobe, cfgStrobe, rxDropped}));
   endtask

   task automatic wrRec(input logic [5:0] a, input logic [71:0] d, input logic rej);
      @(posedge clock);
      #1;
      satWrEn = 1'b1;
      satWrAddr = a;
      satWrData = d;
      @(posedge clock);
      #1;
      satWrEn = 1'b0;
      chk("satWrRejected", 32'(rej), 32'(satWrRejected));
   endtask

   // one-cycle start request: epoch when sel is high, temperature otherwise
   task automatic pulse(input logic sel);
      @(posedge clock);
      #1;
      epochStart = sel;
      tempStart = ~sel;
      @(posedge clock);
      #1;
      epochStart = 1'b0;
      tempStart = 1'b0;
   endtask

   task automatic waitIdle();
      int k;
      k = 0;
      while (k < 3000 && (encBusy !== 1'b0 || txValid !== 1'b0))
      begin
         @(posedge clock);
         #1;
         k++;
      end
      if (k == 3000)
      begin
         mismatches++;
         $display("CHECK FAILED encoderIdle expected 0 seen busy");
         finalReport();
      end
   endtask

   task automatic cmpTx();
      chk("txCount", 32'(exq.size()), 32'(i_host.got.size()));
      for (int i = 0; i < exq.size() && i < i_host.got.size(); i++)
         chk("txByte", 32'(exq[i]), 32'(i_host.got[i]));
      exq.delete();
      i_host.got.delete();
   endtask

   // split into packets of at most 28 records, flag upper nibble cleared
   task automatic expSat(input int n);
      logic [7:0] b[$];
      logic [7:0] v;
      int         tot;
      int         cnt;
      tot = (n == 0) ? 1 : (n + 27) / 28;
      for (int p = 0; p < tot; p++)
      begin
         cnt = (n - 28 * p > 28) ? 28 : n - 28 * p;
         b = {8'(tot), 8'(p + 1)};
         for (int r = 0; r < cnt * 9; r++)
         begin
            v = rec[28 * p + r / 9][8 * (r % 9) +: 8];
            b.push_back((r % 9 == 8) ? (v & `FLAG_MASK) : v);
         end
         foreach (b[j])
            exq.push_back(ent(j == 0, j == b.size() - 1, `ID_EXTSAT, 8'(b.size()), b[j]));
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      logic [31:0] durs[3];
      logic [7:0]  ids[18];
      logic [7:0]  lens[18];
      logic [7:0]  b0;
      logic [71:0] r;
      int          m;
      int          sc[7];
      durs = '{32'h3DCCCCCD, 32'h3F800000, 32'h40000000};
      ids = '{8'h54, 8'h55, 8'hBF, 8'hB4, 8'hB5, 8'hB6, 8'hB8, 8'hB9, 8'hBA, 8'hBC, 8'hC3,
              8'hC5, 8'hC6, 8'hC7, 8'hCA, 8'hCB, 8'hBE, 8'hC1};
      lens = '{8'h0B, 8'h20, 8'h03, 8'h04, 8'h0C, 8'h11, 8'h04, 8'h49, 8'h11, 8'h0D, 8'hB7,
               8'h55, 8'h40, 8'h41, 8'h1E, 8'h1E, 8'h01, 8'h05};
      sc = '{0, 1, 28, 29, 56, 57, 63};
      void'($urandom(32'h0FED));
      repeat (2) @(posedge clock);
      #1;
      srst = 1'b0;
      chk("resetOutputs", 32'h0, 32'({zavStrobe, cfgStrobe, rxDropped, txValid, encBusy}));
      // durations at both ends of the allowed span, little-endian float
      foreach (durs[i])
      begin
         for (int k = 0; k < 8; k++)
            i_host.pay.push_back((k < 4) ? durs[i][8 * k +: 8] : 8'h00);
         rxPkt(`ID_ZAV, `LEN_ZAV, 3'h4);
         chk("zavDuration", durs[i], zavDuration);
      end
      // a set reserved byte or a short packet must leave the duration alone
      m = $urandom_range(7, 4);
      for (int k = 0; k < 8; k++)
         i_host.pay.push_back((k == m) ? 8'h01 : ((k < 4) ? 8'h3C : 8'h00));
      rxPkt(`ID_ZAV, `LEN_ZAV, 3'h1);
      fill(7, 8'h00);
      rxPkt(`ID_ZAV, 8'h07, 3'h1);
      chk("zavKept", durs[2], zavDuration);
      // read-only ids first, then the config ids except BD, C0, C2 and C4, each also with a wrong length
      foreach (ids[i])
      begin
         b0 = 8'($urandom_range(1));
         if (ids[i] == 8'hB4)
         begin
            m = 1000 * $urandom_range(65, 1);
            i_host.pay = {b0, 8'h00, m[7:0], m[15:8]};
         end
         else
            fill(int'(lens[i]), b0);
         rxPkt(ids[i], lens[i], (i < 3) ? 3'h1 : 3'h2);
         if (i >= 3)
         begin
            m = (ids[i] == `ID_MAGCFG || ids[i] == `ID_ZEROALIGN) ? 0 : int'(b0[0]);
            chk("cfgId", 32'(ids[i]), 32'(cfgId));
            chk("cfgPermanent", 32'(m), 32'(cfgPermanent));
            fill(int'(lens[i]) + 1, 8'h00);
            rxPkt(ids[i], lens[i] + 8'h01, 3'h1);
            chk("cfgIdKept", 32'(ids[i]), 32'(cfgId));
         end
      end
      // records with noisy flag bits, boundary codes at address 1
      for (int a = 0; a < 64; a++)
      begin
         r[31:0] = $urandom;
         r[63:32] = $urandom;
         r[71:64] = 8'($urandom);
         r[7:0] = (a == 1) ? `SYS_MAX : 8'($urandom_range(9));
         r[23:16] = (a == 1) ? `FREQ_MAX : 8'($urandom_range(10));
         wrRec(6'(a), r, 1'b0);
         rec[a] = r;
      end
      wrRec(6'h00, {rec[0][71:8], 8'h0A}, 1'b1);
      wrRec(6'h02, {rec[2][71:24], 8'h0B, rec[2][15:0]}, 1'b1);
      // epochs around the 28-record split; a temperature start mid-epoch is ignored
      foreach (sc[i])
      begin
         satCount = 6'(sc[i]);
         i_host.stallPct = (i % 2) * 40;
         pulse(1'b1);
         if (i == 6)
         begin
            repeat (5) @(posedge clock);
            pulse(1'b0);
         end
         expSat(sc[i]);
         waitIdle();
         cmpTx();
      end
      // temperature packet with and without back-pressure
      for (int t = 0; t < 2; t++)
      begin
         for (int k = 0; k < 8; k++)
            tempData[32 * k +: 32] = $urandom;
         i_host.stallPct = 50 * t;
         pulse(1'b0);
         for (int k = 0; k < 32; k++)
            exq.push_back(ent(k == 0, k == 31, `ID_TEMP, `LEN_TEMP, tempData[8 * k +: 8]));
         waitIdle();
         cmpTx();
      end
      finalReport();
   end
endmodule
`default_nettype wire
